// ### logic/qd_consts.svh
// Purpose: Named offsets, field positions, reset values and timing figures of the quadrature decoder
// Assumes: Included by its bare name
// Notes:   Definitions only
`ifndef QD_CONSTS_SVH
`define QD_CONSTS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define QD_OFF_START    12'h000
`define QD_OFF_STOP     12'h004
`define QD_OFF_SNAPBOTH 12'h008
`define QD_OFF_SNAPMOT  12'h00C
`define QD_OFF_SNAPDBL  12'h010
`define QD_OFF_STATUS   12'h100
`define QD_OFF_LINKS    12'h200
`define QD_OFF_MASKSET  12'h304
`define QD_OFF_MASKCLR  12'h308
`define QD_OFF_ON       12'h500
`define QD_OFF_POL      12'h504
`define QD_OFF_SPER     12'h508
`define QD_OFF_SAMPLE   12'h50C
`define QD_OFF_RPER     12'h510
`define QD_OFF_TOTAL    12'h514
`define QD_OFF_TSNAP    12'h518
`define QD_OFF_PLAMP    12'h51C
`define QD_OFF_PA       12'h520
`define QD_OFF_PB       12'h524
`define QD_OFF_DBL      12'h544
`define QD_OFF_DBLSNAP  12'h548
// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define QD_EV_SAMPLE    0
`define QD_EV_REPORT    1
`define QD_EV_OVF       2
`define QD_EV_DBL       3
`define QD_EV_HALT      4
`define QD_LNK_HALT     5
`define QD_LNK_SNAP     6
`define QD_PSEL_CONN    31
`define QD_EV_ALL       5'h1F
`define QD_PSEL_RST     6'h3F
`define QD_DBL_MAX      4'hF
`define QD_SPER_MAXCODE 4'hA
`define QD_TOTAL_MAX    32'h7FFFFFFF
`define QD_TOTAL_MIN    32'h80000000
`define QD_SAMP_ZERO    32'h00000000
`define QD_SAMP_PLUS    32'h00000001
`define QD_SAMP_MINUS   32'hFFFFFFFF
`define QD_SAMP_DOUBLE  32'h00000002
`define QD_RPT_0        8'h0A
`define QD_RPT_1        8'h28
`define QD_RPT_2        8'h50
`define QD_RPT_3        8'h78
`define QD_RPT_4        8'hA0
`define QD_RPT_5        8'hC8
`define QD_RPT_6        8'hF0
// ----------------------------------------
// Timing
// ----------------------------------------
`define QD_SAMPLE_US    128
`define QD_CLK_MHZ      250
`endif

// ### logic/qd_pkg.sv
// Purpose: Types shared by the quadrature decoder
// Assumes: Nothing
// Notes:   Pin select keeps only the connect bit and pin number
package qd_pkg;
  typedef struct packed {
    logic       disc;
    logic [4:0] pin;
  } qd_psel_s;
  typedef enum logic [0:0] {
    QD_IDLE = 1'b0,
    QD_RUN  = 1'b1
  } qd_state_e;
endpackage

// ### logic/qd_regs.sv
// Purpose: Quadrature decoder with its register file on an Avalon-MM slave
// Assumes: Encoder phases arrive asynchronously on gpio_in and pass two flops
// Notes:   Bus answers one cycle after a request; lamp lit while the decoder runs
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ns
`include "qd_consts.svh"
// Operation
// - Writing one to mask-set enables that event's interrupt; reads show enables.
// - Writing one to mask-clear disables that interrupt; reads show the same enables.
// - Enable bit 1 activates the decoder pins, 0 deactivates the decoder.
// - While disabled the selected pins are released for ordinary use.
// - Lamp polarity 0 drives lamp active low, 1 active high.
// - Sample interval sets sample period, code 0 is 128 us; sample rewritten each time.
// - Report interval codes 0 to 6 pick 10 to 240 samples per report.
// - Report period equals sample period times samples per report.
// - Only valid steps are added to the total; doubles are never added.
// - Motion total is 32 bit signed, read only.
// - A sample that would overflow the total is dropped and flags overflow.
// - Either total snapshot task clears the motion total.
// - Snapshot register captures the total on either snapshot task only.
// - Lamp pin select holds pin 0 to 31 and a disconnect bit.
// - Phase pin selects hold pin and disconnect bit; disconnected phase reads nothing.
// - A sample is +1 or -1 for a step, 2 for a double transition.
// - Snapshot-both copies and clears both total and double count.
// - New-sample event fires on every write of the motion sample.
module qd_regs
  import qd_pkg::*;
#(
  parameter int BASE_CYC = `QD_SAMPLE_US * `QD_CLK_MHZ
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Avalon-MM slave
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Interrupt
  output logic             irq,
  // Pins
  input  wire logic [31:0] gpio_in,
  output logic      [31:0] lamp_out,
  output logic      [31:0] lamp_oe,
  output logic      [31:0] pin_owned
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [4:0]  irq_mask, evt_status;
  logic [1:0]  event_task_links;
  logic        decoder_on, lamp_polarity;
  logic [3:0]  sample_interval, report_interval;
  logic [31:0] motion_sample, motion_total, motion_total_snapshot;
  logic [3:0]  double_transition_count, dbl_snapshot;
  qd_psel_s    lamp_pin_select, phase_a_pin_select, phase_b_pin_select;
  qd_state_e   state;
  logic [31:0] per_cnt;
  logic [7:0]  rpt_cnt;
  logic        rpt_move, rpt_dbl;
  logic [1:0]  prev_ab;
  logic [31:0] gpio_s1, gpio_s2;

  logic [4:0]  next_irq_mask, next_evt_status;
  logic [1:0]  next_event_task_links;
  logic        next_decoder_on, next_lamp_polarity, next_irq, next_waitrequest;
  logic [3:0]  next_sample_interval, next_report_interval;
  logic [31:0] next_motion_sample, next_motion_total, next_motion_total_snapshot, next_readdata;
  logic [3:0]  next_double_transition_count, next_dbl_snapshot;
  qd_psel_s    next_lamp_pin_select, next_phase_a_pin_select, next_phase_b_pin_select;
  qd_state_e   next_state;
  logic [31:0] next_per_cnt, per_last;
  logic [7:0]  next_rpt_cnt, rpt_target;
  logic        next_rpt_move, next_rpt_dbl;
  logic [1:0]  next_prev_ab, ab, diff;
  logic [31:0] next_lamp_out, next_lamp_oe, next_pin_owned;

  logic        wr_hit, rd_hit, tick, step, dbl, ovf, stop, snap_both, snap_mot, snap_dbl;
  logic [4:0]  ev;
  logic [3:0]  sper;

  function automatic logic [1:0] qd_pos(input logic [1:0] p);
    unique case (p)
      2'h0: qd_pos = 2'h0;
      2'h1: qd_pos = 2'h1;
      2'h3: qd_pos = 2'h2;
      2'h2: qd_pos = 2'h3;
    endcase
  endfunction

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    wr_hit = avs_write & ~avs_waitrequest;
    rd_hit = avs_read & ~avs_waitrequest;
    // Disconnected phase reads low so it never fakes a step
    ab[1] = phase_a_pin_select.disc ? 1'b0 : gpio_s2[phase_a_pin_select.pin];
    ab[0] = phase_b_pin_select.disc ? 1'b0 : gpio_s2[phase_b_pin_select.pin];
    sper = (sample_interval > `QD_SPER_MAXCODE) ? `QD_SPER_MAXCODE : sample_interval;
    per_last = (32'(BASE_CYC) << sper) - 32'h1;
    unique case (report_interval)
      4'h0:    rpt_target = `QD_RPT_0;
      4'h1:    rpt_target = `QD_RPT_1;
      4'h2:    rpt_target = `QD_RPT_2;
      4'h3:    rpt_target = `QD_RPT_3;
      4'h4:    rpt_target = `QD_RPT_4;
      4'h5:    rpt_target = `QD_RPT_5;
      default: rpt_target = `QD_RPT_6;
    endcase
    // Compared with >= so a shorter interval written mid-run cannot strand the counter
    tick = (state == QD_RUN) && (per_cnt >= per_last);
    diff = 2'(qd_pos(ab) - qd_pos(prev_ab));
    step = tick && diff[0];
    dbl  = tick && (diff == 2'h2);
    ovf  = step && ((diff == 2'h1 && motion_total == `QD_TOTAL_MAX) ||
                    (diff == 2'h3 && motion_total == `QD_TOTAL_MIN));
    ev = 5'h0;
    next_state = state;
    next_per_cnt = (state == QD_RUN && !tick) ? per_cnt + 32'h1 : 32'h0;
    next_prev_ab = prev_ab;
    next_motion_sample = motion_sample;
    next_motion_total = motion_total;
    next_double_transition_count = double_transition_count;
    next_rpt_cnt = rpt_cnt;
    next_rpt_move = rpt_move;
    next_rpt_dbl = rpt_dbl;
    if (tick) begin
      ev[`QD_EV_SAMPLE] = 1'b1;
      next_prev_ab = ab;
      unique case (diff)
        2'h0: next_motion_sample = `QD_SAMP_ZERO;
        2'h1: next_motion_sample = `QD_SAMP_PLUS;
        2'h3: next_motion_sample = `QD_SAMP_MINUS;
        2'h2: next_motion_sample = `QD_SAMP_DOUBLE;
      endcase
      // Report window counts every sample, whatever its value
      if (8'(rpt_cnt + 8'h1) >= rpt_target) begin
        ev[`QD_EV_REPORT] = rpt_move | step;
        ev[`QD_EV_DBL] = rpt_dbl | dbl;
        next_rpt_cnt = 8'h0;
        next_rpt_move = 1'b0;
        next_rpt_dbl = 1'b0;
      end else begin
        next_rpt_cnt = rpt_cnt + 8'h1;
        next_rpt_move = rpt_move | step;
        next_rpt_dbl = rpt_dbl | dbl;
      end
    end
    if (ovf)
      ev[`QD_EV_OVF] = 1'b1;
    else if (step)
      next_motion_total = motion_total + next_motion_sample;
    if (dbl) begin
      if (double_transition_count == `QD_DBL_MAX)
        ev[`QD_EV_OVF] = 1'b1;
      else
        next_double_transition_count = double_transition_count + 4'h1;
    end
    // Snapshot sees this cycle's sample, so a linked snapshot never loses it
    snap_both = (wr_hit && avs_address == `QD_OFF_SNAPBOTH && avs_writedata[0]) ||
                (event_task_links[`QD_LNK_SNAP - `QD_LNK_HALT] && ev[`QD_EV_SAMPLE]);
    snap_mot = snap_both || (wr_hit && avs_address == `QD_OFF_SNAPMOT && avs_writedata[0]);
    snap_dbl = snap_both || (wr_hit && avs_address == `QD_OFF_SNAPDBL && avs_writedata[0]);
    next_motion_total_snapshot = snap_mot ? next_motion_total : motion_total_snapshot;
    if (snap_mot)
      next_motion_total = 32'h0;
    next_dbl_snapshot = snap_dbl ? next_double_transition_count : dbl_snapshot;
    if (snap_dbl)
      next_double_transition_count = 4'h0;
    stop = (wr_hit && avs_address == `QD_OFF_STOP && avs_writedata[0]) ||
           (event_task_links[0] && ev[`QD_EV_DBL]);
    if (!decoder_on) begin
      next_state = QD_IDLE;
    end else if (state == QD_RUN && stop) begin
      next_state = QD_IDLE;
      ev[`QD_EV_HALT] = 1'b1;
    end else if (state == QD_IDLE && wr_hit && avs_address == `QD_OFF_START && avs_writedata[0]) begin
      next_state = QD_RUN;
      next_prev_ab = ab;
      next_rpt_cnt = 8'h0;
      next_rpt_move = 1'b0;
      next_rpt_dbl = 1'b0;
    end
    // Register writes take effect on the edge that ends the request
    next_irq_mask = irq_mask;
    next_event_task_links = event_task_links;
    next_decoder_on = decoder_on;
    next_lamp_polarity = lamp_polarity;
    next_sample_interval = sample_interval;
    next_report_interval = report_interval;
    next_lamp_pin_select = lamp_pin_select;
    next_phase_a_pin_select = phase_a_pin_select;
    next_phase_b_pin_select = phase_b_pin_select;
    if (wr_hit) begin
      unique case (avs_address)
        `QD_OFF_MASKSET: next_irq_mask = irq_mask | avs_writedata[4:0];
        `QD_OFF_MASKCLR: next_irq_mask = irq_mask & ~avs_writedata[4:0];
        `QD_OFF_LINKS:   next_event_task_links = avs_writedata[`QD_LNK_SNAP:`QD_LNK_HALT];
        `QD_OFF_ON:      next_decoder_on = avs_writedata[0];
        `QD_OFF_POL:     next_lamp_polarity = avs_writedata[0];
        `QD_OFF_SPER:    next_sample_interval = avs_writedata[3:0];
        `QD_OFF_RPER:    next_report_interval = avs_writedata[3:0];
        `QD_OFF_PLAMP:   next_lamp_pin_select = {avs_writedata[`QD_PSEL_CONN], avs_writedata[4:0]};
        `QD_OFF_PA:      next_phase_a_pin_select = {avs_writedata[`QD_PSEL_CONN], avs_writedata[4:0]};
        `QD_OFF_PB:      next_phase_b_pin_select = {avs_writedata[`QD_PSEL_CONN], avs_writedata[4:0]};
        default: ;
      endcase
    end
    // A new event wins over the read; only bits that the read returned are cleared
    next_evt_status = (rd_hit && avs_address == `QD_OFF_STATUS) ?
                      ((evt_status & ~avs_readdata[4:0]) | ev) : (evt_status | ev);
    next_irq = |(next_evt_status & next_irq_mask);
    // One-cycle answer: waitrequest drops one cycle after a request arrives
    next_waitrequest = !((avs_read || avs_write) && avs_waitrequest);
    next_readdata = avs_readdata;
    if (avs_read && avs_waitrequest) begin
      unique case (avs_address)
        `QD_OFF_STATUS:  next_readdata = {27'h0, evt_status};
        `QD_OFF_LINKS:   next_readdata = {25'h0, event_task_links, 5'h0};
        `QD_OFF_MASKSET,
        `QD_OFF_MASKCLR: next_readdata = {27'h0, irq_mask};
        `QD_OFF_ON:      next_readdata = {31'h0, decoder_on};
        `QD_OFF_POL:     next_readdata = {31'h0, lamp_polarity};
        `QD_OFF_SPER:    next_readdata = {28'h0, sample_interval};
        `QD_OFF_SAMPLE:  next_readdata = motion_sample;
        `QD_OFF_RPER:    next_readdata = {28'h0, report_interval};
        `QD_OFF_TOTAL:   next_readdata = motion_total;
        `QD_OFF_TSNAP:   next_readdata = motion_total_snapshot;
        `QD_OFF_PLAMP:   next_readdata = {lamp_pin_select.disc, 26'h0, lamp_pin_select.pin};
        `QD_OFF_PA:      next_readdata = {phase_a_pin_select.disc, 26'h0, phase_a_pin_select.pin};
        `QD_OFF_PB:      next_readdata = {phase_b_pin_select.disc, 26'h0, phase_b_pin_select.pin};
        `QD_OFF_DBL:     next_readdata = {28'h0, double_transition_count};
        `QD_OFF_DBLSNAP: next_readdata = {28'h0, dbl_snapshot};
        default:         next_readdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // Pin ownership and lamp drive
  // ----------------------------------------
  generate
    for (genvar i = 0; i < 32; i++) begin : g_pin
      logic lamp_here;
      assign lamp_here = decoder_on && !lamp_pin_select.disc && lamp_pin_select.pin == 5'(i);
      assign next_lamp_oe[i] = lamp_here;
      assign next_lamp_out[i] = lamp_here && ((state == QD_RUN) ~^ lamp_polarity ? 1'b0 : 1'b1) ^ 1'b1;
      assign next_pin_owned[i] = decoder_on && (lamp_here ||
        (!phase_a_pin_select.disc && phase_a_pin_select.pin == 5'(i)) ||
        (!phase_b_pin_select.disc && phase_b_pin_select.pin == 5'(i)));
    end
  endgenerate

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    gpio_s1 <= gpio_in;
    gpio_s2 <= gpio_s1;
    if (!resetn) begin
      irq_mask <= 5'h0;
      evt_status <= 5'h0;
      irq <= 1'b0;
      event_task_links <= 2'h0;
      decoder_on <= 1'b0;
      lamp_polarity <= 1'b0;
      sample_interval <= 4'h0;
      report_interval <= 4'h0;
      motion_sample <= 32'h0;
      motion_total <= 32'h0;
      motion_total_snapshot <= 32'h0;
      double_transition_count <= 4'h0;
      dbl_snapshot <= 4'h0;
      lamp_pin_select <= `QD_PSEL_RST;
      phase_a_pin_select <= `QD_PSEL_RST;
      phase_b_pin_select <= `QD_PSEL_RST;
      state <= QD_IDLE;
      per_cnt <= 32'h0;
      rpt_cnt <= 8'h0;
      rpt_move <= 1'b0;
      rpt_dbl <= 1'b0;
      prev_ab <= 2'h0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      lamp_out <= 32'h0;
      lamp_oe <= 32'h0;
      pin_owned <= 32'h0;
    end else begin
      irq_mask <= next_irq_mask;
      evt_status <= next_evt_status;
      irq <= next_irq;
      event_task_links <= next_event_task_links;
      decoder_on <= next_decoder_on;
      lamp_polarity <= next_lamp_polarity;
      sample_interval <= next_sample_interval;
      report_interval <= next_report_interval;
      motion_sample <= next_motion_sample;
      motion_total <= next_motion_total;
      motion_total_snapshot <= next_motion_total_snapshot;
      double_transition_count <= next_double_transition_count;
      dbl_snapshot <= next_dbl_snapshot;
      lamp_pin_select <= next_lamp_pin_select;
      phase_a_pin_select <= next_phase_a_pin_select;
      phase_b_pin_select <= next_phase_b_pin_select;
      state <= next_state;
      per_cnt <= next_per_cnt;
      rpt_cnt <= next_rpt_cnt;
      rpt_move <= next_rpt_move;
      rpt_dbl <= next_rpt_dbl;
      prev_ab <= next_prev_ab;
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
      lamp_out <= next_lamp_out;
      lamp_oe <= next_lamp_oe;
      pin_owned <= next_pin_owned;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_MASK_SET: assert property (wr_hit && avs_address == `QD_OFF_MASKSET && avs_writedata[0]
    |=> irq_mask[0]) else $error("mask set write did not enable");
  AST_MASK_CLR: assert property (wr_hit && avs_address == `QD_OFF_MASKCLR && avs_writedata[3]
    |=> !irq_mask[3]) else $error("mask clear write did not disable");
  AST_OFF_IDLE: assert property (!decoder_on |=> state == QD_IDLE)
    else $error("decoder runs while switched off");
  AST_PINS_FREE: assert property (!decoder_on ##1 !decoder_on |=> pin_owned == 32'h0 && lamp_oe == 32'h0)
    else $error("pins held while decoder off");
  AST_LAMP_POL: assert property (state == QD_RUN && decoder_on && !lamp_pin_select.disc
    ##1 $stable(lamp_polarity) |-> lamp_out[$past(lamp_pin_select.pin)] == $past(lamp_polarity))
    else $error("lamp level wrong");
  AST_SAMPLE_EVT: assert property (tick |=> evt_status[`QD_EV_SAMPLE] ##1 $stable(motion_sample) || tick)
    else $error("new sample without event");
  AST_NO_DOUBLE: assert property (dbl && !snap_mot |=> motion_total == $past(motion_total))
    else $error("double transition added to total");
  AST_OVF_HOLD: assert property (ovf && !snap_mot |=> motion_total == $past(motion_total)
    && evt_status[`QD_EV_OVF]) else $error("overflow sample not discarded");
  AST_SNAP: assert property (snap_mot && !tick |=> motion_total == 32'h0
    && motion_total_snapshot == $past(motion_total)) else $error("snapshot task wrong");
  AST_BUS_ONE: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer not one cycle");

  AST_IRQ_LEVEL: assert property (irq == |(evt_status & irq_mask))
    else $error("interrupt level disagrees with status and mask");

  AST_TOTAL_STEP: assert property (step && !ovf && !snap_mot
    |=> motion_total == $past(motion_total) + motion_sample) else $error("step not added to total");

  AST_SAMPLE_VAL: assert property (tick |=> motion_sample inside
    {`QD_SAMP_ZERO, `QD_SAMP_PLUS, `QD_SAMP_MINUS, `QD_SAMP_DOUBLE}) else $error("sample value out of range");

  AST_DBL_SAT: assert property (dbl && double_transition_count == `QD_DBL_MAX && !snap_dbl
    |=> double_transition_count == `QD_DBL_MAX && evt_status[`QD_EV_OVF]) else $error("double count wrapped");

  AST_HALT_LINK: assert property (state == QD_RUN && decoder_on && event_task_links[0] && ev[`QD_EV_DBL]
    |=> state == QD_IDLE && evt_status[`QD_EV_HALT]) else $error("double seen did not halt");

  AST_SNAP_LINK: assert property (event_task_links[1] && tick |=> motion_total == 32'h0)
    else $error("new sample did not snapshot");

  AST_NO_REPORT: assert property (tick && 8'(rpt_cnt + 8'h1) < rpt_target
    |=> !$rose(evt_status[`QD_EV_REPORT])) else $error("report before window ends");

  AST_TOTAL_RO: assert property (wr_hit && avs_address == `QD_OFF_TOTAL && !step && !snap_mot
    |=> motion_total == $past(motion_total)) else $error("total took a bus write");
endmodule

// ### tb/qd_enc_model.sv
// Purpose: Behavioural two-phase encoder standing on the decoder's pins
// Assumes: Phase pin numbers match what the bench writes into the pin selects
// Notes:   Unused pins toggle every cycle so a wrong pin choice cannot pass
`timescale 1ns/1ns
module qd_enc_model
  import qd_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Motion: 0 hold, 1 forward, 2 back, 3 double jump
  input  wire logic [1:0]  move,
  input  wire logic [4:0]  pin_a,
  input  wire logic [4:0]  pin_b,
  // Pin levels
  output logic      [31:0] gpio
);
  logic [1:0] pos = 2'h0;
  logic       tog = 1'b0;
  logic [1:0] ab;
  always_ff @(posedge clk) begin
    tog <= ~tog;
    case (move)
      2'h1:    pos <= pos + 2'h1;
      2'h2:    pos <= pos - 2'h1;
      2'h3:    pos <= pos + 2'h2;
      default: pos <= pos;
    endcase
  end
  // Gray order 00,01,11,10 with A as msb; a jump of two is a double
  always_comb begin
    ab = {pos[1], pos[1] ^ pos[0]};
    gpio = {32{tog}};
    gpio[pin_a] = ab[1];
    gpio[pin_b] = ab[0];
  end
endmodule

// ### tb/qd_regs_test.sv
// Purpose: Self-checking bench for the decoder register file
// Assumes: Encoder model on pins 5 and 6, lamp on pin 3
// Notes:   BASE_CYC cut to 20 so report windows stay short
`timescale 1ns/1ns
`include "qd_consts.svh"
module qd_regs_test;
  localparam int B = 20;
  localparam logic [11:0] RA [13] = '{`QD_OFF_MASKSET, `QD_OFF_MASKCLR, `QD_OFF_ON, `QD_OFF_POL, `QD_OFF_SPER,
    `QD_OFF_SAMPLE, `QD_OFF_RPER, `QD_OFF_TOTAL, `QD_OFF_TSNAP, `QD_OFF_PLAMP, `QD_OFF_PA, `QD_OFF_PB, 12'h600};
  localparam logic [31:0] RV [13] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h8000001F, 32'h8000001F, 32'h8000001F, 32'h0};
  localparam logic [1:0]  SC [5] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h0};
  localparam logic [31:0] SE [5] = '{32'h1, 32'h1, 32'hFFFFFFFF, 32'h2, 32'h0};
  localparam int          RP [7] = '{10, 40, 80, 120, 160, 200, 240};
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic [31:0] gpio_in;
  logic [31:0] lamp_out;
  logic [31:0] lamp_oe;
  logic [31:0] pin_owned;
  logic [1:0]  move = 2'h0;
  logic [31:0] d;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          t0;
  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  qd_regs #(.BASE_CYC(B)) dut_u (.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .gpio_in(gpio_in), .lamp_out(lamp_out), .lamp_oe(lamp_oe),
    .pin_owned(pin_owned));
  qd_enc_model enc_u (.clk(clk), .move(move), .pin_a(5'h05), .pin_b(5'h06), .gpio(gpio_in));
  // ----------------------------------------
  // Bus and helper tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request held until the edge that sees waitrequest low, then released
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= ~w;
    avs_write <= w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    bus(1'b1, a, v);
  endtask
  task automatic rd(input logic [11:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    @(negedge clk);
    while (irq !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (n >= lim) n_mismatch++;
  endtask
  task automatic mv(input logic [1:0] c);
    @(posedge clk);
    move <= c;
    @(posedge clk);
    move <= 2'h0;
  endtask
  // Move right after one sample, then read the next one
  task automatic do_step(input logic [1:0] c, input logic [31:0] e);
    rd(`QD_OFF_STATUS);
    wait_irq(4 * B);
    mv(c);
    rd(`QD_OFF_STATUS);
    wait_irq(4 * B);
    rd(`QD_OFF_SAMPLE);
    chk(d, e);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      rd(RA[i]);
      chk(d, RV[i]);
    end
    wr(`QD_OFF_TOTAL, 32'h00001234);
    rd(`QD_OFF_TOTAL);
    chk(d, 32'h0);
    $display("test reset done");
    wr(`QD_OFF_MASKSET, 32'h0000001F);
    rd(`QD_OFF_MASKSET);
    chk(d, 32'h1F);
    wr(`QD_OFF_MASKCLR, 32'h00000005);
    rd(`QD_OFF_MASKCLR);
    chk(d, 32'h1A);
    rd(`QD_OFF_MASKSET);
    chk(d, 32'h1A);
    wr(`QD_OFF_MASKCLR, 32'h0000001F);
    $display("test mask done");
    wr(`QD_OFF_PLAMP, 32'h00000003);
    wr(`QD_OFF_PA, 32'h00000005);
    wr(`QD_OFF_PB, 32'h00000006);
    rd(`QD_OFF_PA);
    chk(d, 32'h5);
    repeat (2) @(negedge clk);
    chk(pin_owned, 32'h0);
    wr(`QD_OFF_ON, 32'h00000001);
    repeat (2) @(negedge clk);
    chk(pin_owned, 32'h68);
    chk(lamp_oe, 32'h8);
    chk(lamp_out, 32'h8);
    wr(`QD_OFF_START, 32'h00000001);
    repeat (2) @(negedge clk);
    chk(lamp_out, 32'h0);
    wr(`QD_OFF_POL, 32'h00000001);
    repeat (2) @(negedge clk);
    chk(lamp_out, 32'h8);
    $display("test pins done");
    wr(`QD_OFF_MASKSET, 32'h00000001);
    for (int i = 0; i < 5; i++) do_step(SC[i], SE[i]);
    rd(`QD_OFF_TOTAL);
    chk(d, 32'h1);
    rd(`QD_OFF_DBL);
    chk(d, 32'h1);
    wr(`QD_OFF_SNAPMOT, 32'h00000001);
    rd(`QD_OFF_TSNAP);
    chk(d, 32'h1);
    rd(`QD_OFF_TOTAL);
    chk(d, 32'h0);
    do_step(2'h1, 32'h1);
    do_step(2'h1, 32'h1);
    wr(`QD_OFF_SNAPBOTH, 32'h00000001);
    rd(`QD_OFF_TSNAP);
    chk(d, 32'h2);
    rd(`QD_OFF_TOTAL);
    chk(d, 32'h0);
    rd(`QD_OFF_DBL);
    chk(d, 32'h0);
    rd(`QD_OFF_DBLSNAP);
    chk(d, 32'h1);
    wr(`QD_OFF_SNAPDBL, 32'h00000001);
    rd(`QD_OFF_TSNAP);
    chk(d, 32'h2);
    $display("test steps done");
    for (int c = 0; c < 3; c++) begin
      wr(`QD_OFF_SPER, 32'(c));
      rd(`QD_OFF_STATUS);
      wait_irq((4 * B) << c);
      rd(`QD_OFF_STATUS);
      wait_irq((4 * B) << c);
      t0 = cyc;
      rd(`QD_OFF_STATUS);
      wait_irq((4 * B) << c);
      chk(32'(cyc - t0), 32'(B << c));
    end
    $display("test period done");
    wr(`QD_OFF_MASKCLR, 32'h0000001F);
    wr(`QD_OFF_MASKSET, 32'h00000002);
    // Last pass doubles the sample period to check the product
    for (int i = 0; i < 8; i++) begin
      wr(`QD_OFF_SPER, (i == 7) ? 32'h1 : 32'h0);
      wr(`QD_OFF_RPER, (i == 7) ? 32'h0 : 32'(i));
      wr(`QD_OFF_STOP, 32'h00000001);
      wr(`QD_OFF_START, 32'h00000001);
      t0 = cyc;
      mv(2'h1);
      rd(`QD_OFF_STATUS);
      wait_irq(B * 500);
      // Irq rises on the report edge; the extra cycle is the start edge itself
      chk(32'(cyc - t0), 32'(((i == 7) ? 20 * B : RP[i] * B) + 1));
    end
    $display("test report done");
    wr(`QD_OFF_SPER, 32'h00000000);
    wr(`QD_OFF_RPER, 32'h00000000);
    wr(`QD_OFF_MASKCLR, 32'h0000001F);
    wr(`QD_OFF_MASKSET, 32'h00000010);
    wr(`QD_OFF_STOP, 32'h00000001);
    wr(`QD_OFF_START, 32'h00000001);
    wr(`QD_OFF_LINKS, 32'h00000020);
    mv(2'h3);
    rd(`QD_OFF_STATUS);
    wait_irq(15 * B);
    rd(`QD_OFF_STATUS);
    chk(d & 32'h18, 32'h18);
    repeat (2) @(negedge clk);
    chk(lamp_out, 32'h0);
    wr(`QD_OFF_SNAPMOT, 32'h00000001);
    wr(`QD_OFF_LINKS, 32'h00000040);
    wr(`QD_OFF_MASKSET, 32'h00000001);
    wr(`QD_OFF_START, 32'h00000001);
    mv(2'h1);
    rd(`QD_OFF_STATUS);
    wait_irq(4 * B);
    rd(`QD_OFF_TSNAP);
    chk(d, 32'h1);
    rd(`QD_OFF_TOTAL);
    chk(d, 32'h0);
    $display("test link done");
    stop_test;
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    stop_test;
  end
endmodule
